// *** design/ddr2_guard_pkg.sv ***
// Contract
// - 1KB page: four activates per 37.5 ns
// - 2KB page: four activates per 50 ns
// - Column commands at least 2 clocks apart
// - Write autoprecharge: WR plus precharge before activate
// - Write data end to read: 7.5/10 ns
// - Read to precharge at least 7.5 ns
// - Self refresh exit: refresh cycle plus 10 ns
// - Self refresh exit to read: 200 clocks
// - Precharge power-down exit: 2 clocks, non-read
// - Fast active power-down exit: 2 clocks, read
// - Slow active power-down exit: 6 minus latency
// - Clock enable held 3 clocks each level
// - Termination change to power-down: 3 clocks
// - Power-down exit to termination timing: 8 clocks
// - Clock runs on after clock enable drops
// - Mode bit 12 picks active exit timing
// - Read to precharge: latency plus half burst
package ddr2_guard_pkg;

	// ----------------------------------------------------------------
	// Clocking
	// ----------------------------------------------------------------
	localparam int  CLK_PS   = 8000;
	localparam int  CK_DIV   = 2;
	localparam int  TCK_PS   = CLK_PS * CK_DIV;
	localparam real TCK_NS   = TCK_PS / 1000.0;
	localparam int  CNT_W    = 8;

	typedef logic [CNT_W-1:0] cnt_t;

	function automatic cnt_t ck_ceil(input real ns);
		int c;
		c = int'($ceil(ns / TCK_NS));
		if (c < 1)
			c = 1;
		return cnt_t'(c);
	endfunction

	// ----------------------------------------------------------------
	// Timing figures and derived clock counts
	// ----------------------------------------------------------------
	localparam real  FAW_1K_NS        = 37.5;
	localparam real  FAW_2K_NS        = 50.0;
	localparam real  WTR_FAST_NS      = 7.5;
	localparam real  WTR_SLOW_NS      = 10.0;
	localparam real  RTP_NS           = 7.5;
	localparam real  XSNR_EXTRA_NS    = 10.0;
	localparam real  SETUP_NS         = 0.35;
	localparam real  HOLD_NS          = 0.475;
	localparam cnt_t FAW_1K_CK        = ck_ceil(FAW_1K_NS);
	localparam cnt_t FAW_2K_CK        = ck_ceil(FAW_2K_NS);
	localparam cnt_t WTR_FAST_CK      = ck_ceil(WTR_FAST_NS);
	localparam cnt_t WTR_SLOW_CK      = ck_ceil(WTR_SLOW_NS);
	localparam cnt_t RTP_CK           = ck_ceil(RTP_NS);
	localparam cnt_t XSNR_EXTRA_CK    = ck_ceil(XSNR_EXTRA_NS);
	localparam cnt_t CLK_HOLD_CK      = ck_ceil(SETUP_NS + TCK_NS + HOLD_NS);
	localparam cnt_t CCD_CK           = 8'h02;
	localparam cnt_t XSRD_CK          = 8'hc8;
	localparam cnt_t XP_CK            = 8'h02;
	localparam cnt_t XARD_CK          = 8'h02;
	localparam cnt_t XARDS_BASE_CK    = 8'h06;
	localparam cnt_t CKE_MIN_CK       = 8'h03;
	localparam cnt_t ANPD_CK          = 8'h03;
	localparam cnt_t AXPD_CK          = 8'h08;
	localparam cnt_t BL_HALF_CK       = 8'h02;

	// ----------------------------------------------------------------
	// Command word layout
	// ----------------------------------------------------------------
	localparam int BANK_W     = 3;
	localparam int ADDR_W     = 14;
	localparam int CMD_W      = 4;
	localparam int WORD_W     = 21;
	localparam int FIFO_DEPTH = 32;
	localparam int CMD_LSB    = 17;
	localparam int BANK_LSB   = 14;
	localparam int AP_BIT     = 10;
	localparam int SLOW_EXIT_BIT = 12;
	localparam int STROBE_SE_BIT = 10;

	localparam logic [CMD_W-1:0] CMD_NOP   = 4'h0;
	localparam logic [CMD_W-1:0] CMD_ACT   = 4'h1;
	localparam logic [CMD_W-1:0] CMD_READ  = 4'h2;
	localparam logic [CMD_W-1:0] CMD_WRITE = 4'h3;
	localparam logic [CMD_W-1:0] CMD_PRE   = 4'h4;
	localparam logic [CMD_W-1:0] CMD_MRS   = 4'h5;
	localparam logic [CMD_W-1:0] CMD_EXTENDED_MODE_REGISTER_SET  = 4'h6;
	localparam logic [CMD_W-1:0] CMD_SREF  = 4'h7;
	localparam logic [CMD_W-1:0] CMD_PDOWN = 4'h8;
	localparam logic [CMD_W-1:0] CMD_WAKE  = 4'h9;
	localparam logic [CMD_W-1:0] CMD_ODT1  = 4'ha;
	localparam logic [CMD_W-1:0] CMD_ODT0  = 4'hb;

	// Pin codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] PIN_NOP   = 4'h7;
	localparam logic [3:0] PIN_ACT   = 4'h3;
	localparam logic [3:0] PIN_READ  = 4'h5;
	localparam logic [3:0] PIN_WRITE = 4'h4;
	localparam logic [3:0] PIN_PRE   = 4'h2;
	localparam logic [3:0] PIN_MODE  = 4'h0;
	localparam logic [3:0] PIN_REF   = 4'h1;
	localparam logic [2:0] BANK_MR   = 3'h0;
	localparam logic [2:0] BANK_EMR  = 3'h1;

endpackage

// *** design/cmd_fifo.sv ***
`timescale 1ns/10ps
module cmd_fifo #(
	parameter int W     = 21,
	parameter int DEPTH = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0]  mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0]   count_reg;
	logic [AW:0]   count_next;
	logic          push;
	logic          pop;

	assign push       = in_valid & in_ready;
	assign pop        = out_valid & out_ready;
	assign out_valid  = count_reg != '0;
	assign out_data   = mem_reg[rd_reg];
	assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_reg] <= in_data;
	end

	// Ready is registered so a long fill path never reaches the source
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			count_reg <= '0;
			in_ready  <= 1'b0;
		end
		else
		begin
			wr_reg    <= wr_reg + AW'(push);
			rd_reg    <= rd_reg + AW'(pop);
			count_reg <= count_next;
			in_ready  <= count_next != (AW+1)'(DEPTH);
		end
	end
endmodule

// *** design/ddr2_command_timing_guard.sv ***
`timescale 1ns/10ps
module ddr2_command_timing_guard (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [20:0]          cmd_data,
	input  wire logic                 cmd_valid,
	output logic                      cmd_ready,
	input  wire logic                 page_2k,
	input  wire logic                 slow_grade,
	input  wire logic [2:0]           cas_latency,
	input  wire logic [2:0]           additive_latency,
	input  wire logic [7:0]           write_recovery_time,
	input  wire logic [7:0]           row_precharge_period,
	input  wire logic [7:0]           refresh_cycle_time,
	output logic                      ck,
	output logic                      ck_n,
	output logic                      cke,
	output logic                      cs_n,
	output logic                      ras_n,
	output logic                      cas_n,
	output logic                      we_n,
	output logic [2:0]                ba,
	output logic [13:0]               a,
	output logic                      termination_control,
	output logic                      strobe_differential,
	output logic                      slow_pd_exit,
	output logic                      asleep
);
	typedef ddr2_guard_pkg::cnt_t cnt_t;

	typedef enum logic [3:0] {
		ST_RUN    = 4'h1,
		ST_SLEEP  = 4'h2,
		ST_CLKOFF = 4'h4,
		ST_WAKE   = 4'h8
	} state_e;

	function automatic cnt_t dec(input cnt_t v);
		return (v == '0) ? v : v - 8'h01;
	endfunction

	function automatic cnt_t cmax(input cnt_t x, input cnt_t y);
		return (x > y) ? x : y;
	endfunction

	// ----------------------------------------------------------------
	// Command queue
	// ----------------------------------------------------------------
	logic [20:0] head;
	logic        head_valid;
	logic        go;

	cmd_fifo #(
		.W     (ddr2_guard_pkg::WORD_W),
		.DEPTH (ddr2_guard_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_data   (cmd_data),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.out_data  (head),
		.out_valid (head_valid),
		.out_ready (go)
	);

	logic [3:0]  hcmd;
	logic [2:0]  hbank;
	logic [13:0] haddr;
	logic        hap;

	assign hcmd  = head[ddr2_guard_pkg::CMD_LSB +: ddr2_guard_pkg::CMD_W];
	assign hbank = head[ddr2_guard_pkg::BANK_LSB +: ddr2_guard_pkg::BANK_W];
	assign haddr = head[ddr2_guard_pkg::ADDR_W-1:0];
	assign hap   = haddr[ddr2_guard_pkg::AP_BIT];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_e     state_reg, state_next;
	logic       div_reg;
	logic       sr_reg, sr_next;
	logic [7:0] open_reg, open_next;
	logic       odt_next;
	logic       slow_next;
	logic       strobe_next;
	cnt_t       faw_reg [4];
	cnt_t       faw_next [4];
	cnt_t       act_reg [8];
	cnt_t       act_next [8];
	cnt_t       pre_reg [8];
	cnt_t       pre_next [8];
	cnt_t       ccd_reg, ccd_next;
	cnt_t       wtr_reg, wtr_next;
	cnt_t       nonread_reg, nonread_next;
	cnt_t       read_reg, read_next;
	cnt_t       ckeh_reg, ckeh_next;
	cnt_t       anpd_reg, anpd_next;
	cnt_t       axpd_reg, axpd_next;
	cnt_t       hold_reg, hold_next;

	logic tick;
	assign tick = div_reg;

	// ----------------------------------------------------------------
	// Derived figures
	// ----------------------------------------------------------------
	cnt_t wl, wr_end, wtr_ck, rd_pre, ards, faw_ck;

	assign wl     = cnt_t'(additive_latency) + cnt_t'(cas_latency) - 8'h01;
	assign wr_end = wl + ddr2_guard_pkg::BL_HALF_CK;
	assign wtr_ck = slow_grade ? ddr2_guard_pkg::WTR_SLOW_CK : ddr2_guard_pkg::WTR_FAST_CK;
	// latency plus half burst, or internal gap
	assign rd_pre = cmax(cnt_t'(additive_latency) + ddr2_guard_pkg::BL_HALF_CK,
		ddr2_guard_pkg::RTP_CK);
	// six minus latency, never under the fast figure
	assign ards   = (additive_latency < 3'h4) ?
		ddr2_guard_pkg::XARDS_BASE_CK - cnt_t'(additive_latency) : ddr2_guard_pkg::XARD_CK;
	assign faw_ck = page_2k ? ddr2_guard_pkg::FAW_2K_CK : ddr2_guard_pkg::FAW_1K_CK;

	// ----------------------------------------------------------------
	// Admission
	// ----------------------------------------------------------------
	logic [3:0] faw_free;
	logic [1:0] faw_slot;
	logic       is_act, is_rd, is_wr, is_pre, is_mr, is_emr;
	logic       is_sref, is_pd, is_wake, is_odt;
	logic       col_ok, cmd_ok, run, sleeping, wake_take, wake_done;

	for (genvar i = 0; i < 4; i++)
	begin : g_faw
		assign faw_free[i] = faw_reg[i] == '0;
	end

	assign faw_slot = faw_free[0] ? 2'h0 : faw_free[1] ? 2'h1 : faw_free[2] ? 2'h2 : 2'h3;

	assign is_act  = hcmd == ddr2_guard_pkg::CMD_ACT;
	assign is_rd   = hcmd == ddr2_guard_pkg::CMD_READ;
	assign is_wr   = hcmd == ddr2_guard_pkg::CMD_WRITE;
	assign is_pre  = hcmd == ddr2_guard_pkg::CMD_PRE;
	assign is_mr   = hcmd == ddr2_guard_pkg::CMD_MRS;
	assign is_emr  = hcmd == ddr2_guard_pkg::CMD_EXTENDED_MODE_REGISTER_SET;
	assign is_sref = hcmd == ddr2_guard_pkg::CMD_SREF;
	assign is_pd   = hcmd == ddr2_guard_pkg::CMD_PDOWN;
	assign is_wake = hcmd == ddr2_guard_pkg::CMD_WAKE;
	assign is_odt  = hcmd == ddr2_guard_pkg::CMD_ODT1 || hcmd == ddr2_guard_pkg::CMD_ODT0;

	assign col_ok = ccd_reg == '0;

	// Head command waits for its gaps
	always_comb
	begin
		cmd_ok = 1'b1;
		if (is_act)
			cmd_ok = (|faw_free) && act_reg[hbank] == '0 && nonread_reg == '0;
		else if (is_rd)
			cmd_ok = col_ok && wtr_reg == '0 && read_reg == '0;
		else if (is_wr)
			cmd_ok = col_ok && nonread_reg == '0;
		else if (is_pre)
			cmd_ok = nonread_reg == '0 && (hap ? pre_reg.or() == '0 : pre_reg[hbank] == '0);
		else if (is_mr || is_emr)
			cmd_ok = nonread_reg == '0;
		else if (is_sref || is_pd)
			cmd_ok = ckeh_reg == '0 && anpd_reg == '0 && nonread_reg == '0;
		else if (is_odt)
			cmd_ok = axpd_reg == '0;
	end

	assign run       = state_reg == ST_RUN;
	assign sleeping  = state_reg == ST_SLEEP || state_reg == ST_CLKOFF;
	assign wake_take = tick && head_valid && sleeping && is_wake && ckeh_reg == '0;
	assign wake_done = tick && state_reg == ST_WAKE && hold_reg == '0;
	assign go        = (tick && head_valid && run && cmd_ok) || wake_take;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		sr_next    = sr_reg;
		case (state_reg)
			ST_RUN:
				if (go && (is_sref || is_pd))
				begin
					state_next = ST_SLEEP;
					sr_next    = is_sref;
				end
			ST_SLEEP:
				if (wake_take)
					state_next = ST_WAKE;
				// clock stops only after the hold time
				else if (tick && sr_reg && hold_reg == '0)
					state_next = ST_CLKOFF;
			ST_CLKOFF:
				if (wake_take)
					state_next = ST_WAKE;
			ST_WAKE:
				if (wake_done)
					state_next = ST_RUN;
			default:
				state_next = ST_RUN;
		endcase
	end

	// ----------------------------------------------------------------
	// Gap counters
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			faw_next[i] = tick ? dec(faw_reg[i]) : faw_reg[i];
		for (int i = 0; i < 8; i++)
		begin
			act_next[i] = tick ? dec(act_reg[i]) : act_reg[i];
			pre_next[i] = tick ? dec(pre_reg[i]) : pre_reg[i];
		end
		ccd_next     = tick ? dec(ccd_reg) : ccd_reg;
		wtr_next     = tick ? dec(wtr_reg) : wtr_reg;
		nonread_next = tick ? dec(nonread_reg) : nonread_reg;
		read_next    = tick ? dec(read_reg) : read_reg;
		ckeh_next    = tick ? dec(ckeh_reg) : ckeh_reg;
		anpd_next    = tick ? dec(anpd_reg) : anpd_reg;
		axpd_next    = tick ? dec(axpd_reg) : axpd_reg;
		hold_next    = tick ? dec(hold_reg) : hold_reg;
		open_next    = open_reg;
		odt_next     = termination_control;
		slow_next    = slow_pd_exit;
		strobe_next  = strobe_differential;
		if (go && run)
		begin
			if (is_act)
			begin
				faw_next[faw_slot] = faw_ck;
				open_next[hbank]   = 1'b1;
			end
			if (is_rd || is_wr)
				ccd_next = ddr2_guard_pkg::CCD_CK;
			if (is_rd)
			begin
				pre_next[hbank] = rd_pre;
				if (hap)
				begin
					act_next[hbank]  = rd_pre + row_precharge_period;
					open_next[hbank] = 1'b0;
				end
			end
			if (is_wr)
			begin
				wtr_next        = wr_end + wtr_ck;
				pre_next[hbank] = wr_end + write_recovery_time;
				if (hap)
				begin
					act_next[hbank]  = wr_end + write_recovery_time + row_precharge_period;
					open_next[hbank] = 1'b0;
				end
			end
			if (is_pre)
			begin
				for (int i = 0; i < 8; i++)
					if (hap || hbank == 3'(i))
					begin
						act_next[i]  = row_precharge_period;
						open_next[i] = 1'b0;
					end
			end
			// mode bit picks the exit flavour
			if (is_mr)
				slow_next = haddr[ddr2_guard_pkg::SLOW_EXIT_BIT];
			if (is_emr)
				strobe_next = !haddr[ddr2_guard_pkg::STROBE_SE_BIT];
			if (is_odt)
			begin
				odt_next  = hcmd == ddr2_guard_pkg::CMD_ODT1;
				anpd_next = ddr2_guard_pkg::ANPD_CK;
			end
			if (is_sref || is_pd)
			begin
				hold_next = ddr2_guard_pkg::CLK_HOLD_CK;
				ckeh_next = ddr2_guard_pkg::CKE_MIN_CK;
			end
		end
		if (wake_take)
			hold_next = ddr2_guard_pkg::CLK_HOLD_CK;
		if (wake_done)
		begin
			ckeh_next = ddr2_guard_pkg::CKE_MIN_CK;
			axpd_next = ddr2_guard_pkg::AXPD_CK;
			if (sr_reg)
			begin
				nonread_next = refresh_cycle_time + ddr2_guard_pkg::XSNR_EXTRA_CK;
				read_next    = ddr2_guard_pkg::XSRD_CK;
			end
			else
			begin
				nonread_next = ddr2_guard_pkg::XP_CK;
				read_next    = (open_reg == '0) ? ddr2_guard_pkg::XP_CK :
					slow_pd_exit ? ards : ddr2_guard_pkg::XARD_CK;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	logic [3:0]  pin_code;
	logic [2:0]  ba_next;
	logic        cke_next;

	assign pin_code = !(go && run) ? ddr2_guard_pkg::PIN_NOP :
		is_act ? ddr2_guard_pkg::PIN_ACT :
		is_rd ? ddr2_guard_pkg::PIN_READ :
		is_wr ? ddr2_guard_pkg::PIN_WRITE :
		is_pre ? ddr2_guard_pkg::PIN_PRE :
		(is_mr || is_emr) ? ddr2_guard_pkg::PIN_MODE :
		is_sref ? ddr2_guard_pkg::PIN_REF : ddr2_guard_pkg::PIN_NOP;
	assign ba_next  = is_mr ? ddr2_guard_pkg::BANK_MR : is_emr ? ddr2_guard_pkg::BANK_EMR : hbank;
	assign cke_next = state_next == ST_RUN;

	// Pins move with ck falling; device samples mid-period
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_reg <= 1'b0;
			ck      <= 1'b0;
			ck_n    <= 1'b1;
			cke     <= 1'b0;
			{cs_n, ras_n, cas_n, we_n} <= 4'hf;
			ba      <= 3'h0;
			a       <= 14'h0000;
			asleep  <= 1'b0;
		end
		else
		begin
			div_reg <= !div_reg;
			ck      <= state_reg != ST_CLKOFF && !div_reg;
			ck_n    <= !(state_reg != ST_CLKOFF && !div_reg);
			asleep  <= state_next != ST_RUN;
			if (tick)
			begin
				cke     <= cke_next;
				{cs_n, ras_n, cas_n, we_n} <= pin_code;
				ba      <= ba_next;
				a       <= haddr;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg           <= ST_RUN;
			sr_reg              <= 1'b0;
			open_reg            <= 8'h00;
			termination_control <= 1'b0;
			slow_pd_exit        <= 1'b0;
			strobe_differential <= 1'b1;
			ccd_reg             <= '0;
			wtr_reg             <= '0;
			nonread_reg         <= '0;
			read_reg            <= '0;
			ckeh_reg            <= ddr2_guard_pkg::CKE_MIN_CK;
			anpd_reg            <= '0;
			axpd_reg            <= '0;
			hold_reg            <= '0;
			faw_reg             <= '{default: '0};
			act_reg             <= '{default: '0};
			pre_reg             <= '{default: '0};
		end
		else
		begin
			state_reg           <= state_next;
			sr_reg              <= sr_next;
			open_reg            <= open_next;
			termination_control <= odt_next;
			slow_pd_exit        <= slow_next;
			strobe_differential <= strobe_next;
			ccd_reg             <= ccd_next;
			wtr_reg             <= wtr_next;
			nonread_reg         <= nonread_next;
			read_reg            <= read_next;
			ckeh_reg            <= ckeh_next;
			anpd_reg            <= anpd_next;
			axpd_reg            <= axpd_next;
			hold_reg            <= hold_next;
			faw_reg             <= faw_next;
			act_reg             <= act_next;
			pre_reg             <= pre_next;
		end
	end
endmodule

// *** tb/ddr2_dev_model.sv ***
`timescale 1ns/10ps
module ddr2_dev_model (
	input  wire logic        ck,
	input  wire logic        cke,
	input  wire logic        cs_n,
	input  wire logic        ras_n,
	input  wire logic        cas_n,
	input  wire logic        we_n,
	input  wire logic [2:0]  ba,
	input  wire logic [13:0] a,
	input  wire logic        page_2k,
	output logic             strobe_diff,
	output logic             slow_exit,
	output int               errors,
	output int               idle_lc,
	output int               ncmd,
	output int               xsrd_gap
);
	// ----------------------------------------
	// Command sampling on rising link clock
	// ----------------------------------------
	wire     [3:0] pins = {cs_n, ras_n, cas_n, we_n};
	logic          cke_s;
	logic          in_sr;
	int            lc;
	int            col_lc;
	int            exit_lc;
	realtime       acts [4];

	initial
	begin
		{strobe_diff, slow_exit, cke_s, in_sr} = 4'h8;
		{errors, idle_lc, ncmd, lc, exit_lc} = 160'h0;
		col_lc = -9;
		xsrd_gap = -1;
		acts = '{default: -1.0e3};
	end

	// No samples while clock stopped
	always @(posedge ck)
	begin
		lc++;
		idle_lc++;
		if (cke && !cke_s)
			exit_lc = lc;
		if (!cke && cke_s)
			in_sr = (pins === ddr2_guard_pkg::PIN_REF);
		if (cke && cke_s && !cs_n && pins !== ddr2_guard_pkg::PIN_NOP)
		begin
			ncmd++;
			idle_lc = 0;
			if (pins === ddr2_guard_pkg::PIN_MODE && ba === ddr2_guard_pkg::BANK_EMR)
				strobe_diff = !a[ddr2_guard_pkg::STROBE_SE_BIT];
			if (pins === ddr2_guard_pkg::PIN_MODE && ba === ddr2_guard_pkg::BANK_MR)
				slow_exit = a[ddr2_guard_pkg::SLOW_EXIT_BIT];
			if (pins === ddr2_guard_pkg::PIN_ACT)
			begin
				if ($realtime - acts[0] < (page_2k ? 50.0 : 37.5))
					errors++;
				acts = '{acts[1], acts[2], acts[3], $realtime};
			end
			if (pins === ddr2_guard_pkg::PIN_READ || pins === ddr2_guard_pkg::PIN_WRITE)
			begin
				if (lc - col_lc < 2)
					errors++;
				col_lc = lc;
			end
			if (pins === ddr2_guard_pkg::PIN_READ && in_sr)
			begin
				xsrd_gap = lc - exit_lc;
				in_sr = 1'b0;
			end
		end
		cke_s = cke;
	end
endmodule

// *** tb/ddr2_guard_chk.sv ***
`timescale 1ns/10ps
module ddr2_guard_chk (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic       ck,
	input wire logic       ck_n,
	input wire logic       cke,
	input wire logic       cs_n,
	input wire logic       ras_n,
	input wire logic       cas_n,
	input wire logic       we_n,
	input wire logic       termination_control,
	input wire logic       asleep,
	input wire logic [7:0] refresh_cycle_time
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic       ck_q, cke_q, term_q, cke_s;
	logic [1:0] mode_reg;
	logic [7:0] cke_age, term_age, col_reg, since_reg;
	wire  [3:0] pins = {cs_n, ras_n, cas_n, we_n};
	wire        samp = ck & ~ck_q;
	wire        cmd  = samp & ~cs_n & cke & cke_s & (pins != ddr2_guard_pkg::PIN_NOP);
	wire        rd   = cmd & (pins == ddr2_guard_pkg::PIN_READ);
	wire        col  = rd | (cmd & (pins == ddr2_guard_pkg::PIN_WRITE));

	function automatic logic [7:0] inc(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction

	// Ages in system clocks: three link clocks are six
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{ck_q, cke_q, term_q, cke_age, term_age} <= {3'h0, 8'h06, 8'h06};
		else
			{ck_q, cke_q, term_q, cke_age, term_age} <= {ck, cke, termination_control,
				(cke != cke_q) ? 8'h01 : inc(cke_age),
				(termination_control != term_q) ? 8'h01 : inc(term_age)};
	end

	// Exit counted only after a real entry
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{cke_s, mode_reg, col_reg, since_reg} <= {3'h0, 8'h02, 8'hff};
		else if (samp)
		begin
			cke_s <= cke;
			col_reg <= col ? 8'h01 : inc(col_reg);
			since_reg <= (cke & ~cke_s & mode_reg[1]) ? 8'h01 : inc(since_reg);
			if (~cke & cke_s)
				mode_reg <= {1'b1, pins == ddr2_guard_pkg::PIN_REF};
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	ck_pair_a: assert property (ck_n == !ck) else $error("ck_n not inverse");
	ck_toggle_a: assert property (!asleep && $past(rst_n) |-> ck != $past(ck))
		else $error("link clock stalled");
	ck_hold_a: assert property ($fell(cke) |-> (ck != $past(ck)) [*3])
		else $error("clock stopped early");
	pins_fall_a: assert property ($changed(pins) |-> $fell(ck))
		else $error("pins moved off tick");
	cke_width_a: assert property ($changed(cke) |-> cke_age >= 8'h06)
		else $error("cke pulse too short");
	term_pd_a: assert property ($fell(cke) |-> term_age >= 8'h06)
		else $error("sleep too soon");
	col_gap_a: assert property (col |-> col_reg >= 8'h02)
		else $error("column gap");
	sref_read_a: assert property (rd && mode_reg[0] |-> since_reg >= 8'hc8)
		else $error("self refresh read gap");
	sref_other_a: assert property (cmd && !rd && mode_reg[0] |->
		since_reg >= refresh_cycle_time + 8'h01)
		else $error("self refresh gap");
	pd_exit_a: assert property (cmd && !mode_reg[0] |-> since_reg >= 8'h02)
		else $error("power-down gap");

	cover property (col && col_reg == 8'h02);
	cover property (rd && mode_reg[0]);
	cover property (cmd && mode_reg == 2'h2 && since_reg < 8'h08);
endmodule

bind ddr2_command_timing_guard ddr2_guard_chk i_chk (.clk(clk), .rst_n(rst_n), .ck(ck),
	.ck_n(ck_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
	.termination_control(termination_control), .asleep(asleep),
	.refresh_cycle_time(refresh_cycle_time));

// *** tb/ddr2_command_timing_guard_bench.sv ***
`timescale 1ns/10ps
module ddr2_command_timing_guard_bench;
	logic        clk, rst_n, cmd_valid, cmd_ready, page_2k, slow_grade;
	logic [20:0] cmd_data;
	logic        ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, term, strobe, slow, asleep;
	logic [2:0]  ba;
	logic [13:0] a;
	logic        m_strobe, m_slow;
	int          m_err, m_idle, m_ncmd, m_gap, num_errors, checks, sent;

	ddr2_command_timing_guard i_dut (.clk(clk), .rst_n(rst_n), .cmd_data(cmd_data),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .page_2k(page_2k),
		.slow_grade(slow_grade), .cas_latency(3'h3), .additive_latency(3'h0),
		.write_recovery_time(8'h03), .row_precharge_period(8'h03),
		.refresh_cycle_time(8'h14), .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a(a),
		.termination_control(term), .strobe_differential(strobe), .slow_pd_exit(slow),
		.asleep(asleep));
	ddr2_dev_model i_dev (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.we_n(we_n), .ba(ba), .a(a), .page_2k(page_2k), .strobe_diff(m_strobe),
		.slow_exit(m_slow), .errors(m_err), .idle_lc(m_idle), .ncmd(m_ncmd),
		.xsrd_gap(m_gap));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Valid stays high between pushes
	task automatic push(input logic [3:0] c, input logic [2:0] b = 3'h0,
		input logic [13:0] ad = 14'h0000);
		logic r;
		int   n;
		cmd_data = {c, b, ad};
		cmd_valid = 1'b1;
		for (n = 0; n < 5000; n++)
		begin
			r = cmd_ready;
			@(posedge clk);
			#1;
			if (r === 1'b1)
				return;
		end
		num_errors++;
		end_sim();
	endtask

	task automatic await(input int n);
		int k;
		cmd_valid = 1'b0;
		for (k = 0; k < 20000; k++)
		begin
			if (m_ncmd >= n && asleep === 1'b0 && m_idle > 8)
				return;
			@(posedge clk);
			#1;
		end
		num_errors++;
		end_sim();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		repeat (2) @(posedge clk);
		#1;
		check("rst cke", cke, 1'b0);
		check("rst ready", cmd_ready, 1'b0);
		check("rst strobe", strobe, 1'b1);
		check("rst slow", {slow, asleep, term}, 3'h0);
		check("rst pins", {cs_n, ras_n, cas_n, we_n, ck, ck_n}, 6'h3d);
		$display("test reset done");
	endtask

	task automatic t_mode();
		int i;
		for (i = 0; i < 2; i++)
		begin
			push(ddr2_guard_pkg::CMD_EXTENDED_MODE_REGISTER_SET, 3'h0, i[0] ? 14'h0400 : 14'h0000);
			push(ddr2_guard_pkg::CMD_MRS, 3'h0, i[0] ? 14'h1000 : 14'h0000);
			sent += 2;
			await(sent);
			check("strobe", {strobe, m_strobe}, {2{~i[0]}});
			check("slow exit", {slow, m_slow}, {2{i[0]}});
		end
		$display("test mode done");
	endtask

	task automatic t_burst();
		int p, b;
		for (p = 0; p < 2; p++)
		begin
			page_2k = p[0];
			slow_grade = p[0];
			for (b = 0; b < 5; b++)
				push(ddr2_guard_pkg::CMD_ACT, b[2:0]);
			push(ddr2_guard_pkg::CMD_WRITE, 3'h0, 14'h0400);
			push(ddr2_guard_pkg::CMD_READ, 3'h1);
			push(ddr2_guard_pkg::CMD_READ, 3'h2);
			push(ddr2_guard_pkg::CMD_WRITE, 3'h3);
			push(ddr2_guard_pkg::CMD_ACT);
			push(ddr2_guard_pkg::CMD_PRE, 3'h0, 14'h0400);
			sent += 11;
			await(sent);
			check("dev errors", m_err, 0);
		end
		$display("test burst done");
	endtask

	task automatic t_pdown();
		push(ddr2_guard_pkg::CMD_ODT1);
		push(ddr2_guard_pkg::CMD_PDOWN);
		push(ddr2_guard_pkg::CMD_WAKE);
		push(ddr2_guard_pkg::CMD_ACT);
		sent += 1;
		await(sent);
		check("term on", term, 1'b1);
		push(ddr2_guard_pkg::CMD_PDOWN);
		push(ddr2_guard_pkg::CMD_WAKE);
		push(ddr2_guard_pkg::CMD_READ);
		push(ddr2_guard_pkg::CMD_ODT0);
		push(ddr2_guard_pkg::CMD_PRE, 3'h0, 14'h0400);
		sent += 2;
		await(sent);
		check("term off", term, 1'b0);
		check("dev errors", m_err, 0);
		$display("test power-down done");
	endtask

	// Read stalls 200 link clocks; queue fills
	task automatic t_sref();
		int   n;
		logic full;
		push(ddr2_guard_pkg::CMD_SREF);
		push(ddr2_guard_pkg::CMD_WAKE);
		push(ddr2_guard_pkg::CMD_READ);
		cmd_data = 21'h0;
		full = 1'b0;
		for (n = 0; n < 64 && !full; n++)
		begin
			@(posedge clk);
			#1;
			full = (cmd_ready === 1'b0);
		end
		check("queue full", full, 1'b1);
		push(ddr2_guard_pkg::CMD_PRE, 3'h0, 14'h0400);
		sent += 2;
		await(sent);
		check("sref read gap", m_gap >= 200, 1'b1);
		check("drained", cmd_ready, 1'b1);
		check("dev errors", m_err, 0);
		$display("test self refresh done");
	endtask

	initial
	begin
		{rst_n, cmd_valid, page_2k, slow_grade} = 4'h0;
		cmd_data = 21'h0;
		{num_errors, checks, sent} = 96'h0;
		t_reset();
		repeat (2) @(posedge clk);
		#1;
		rst_n = 1'b1;
		t_mode();
		t_burst();
		t_pdown();
		t_sref();
		end_sim();
	end
endmodule
